// file: verification/digipot_link_sva.sv
/*
  Checker for the serial wiper control link, sampled on the core clock.
  Assumes link signals from the interface joining host and device.
*/
`timescale 1ns/1ps
module digipot_link_sva
  import digipot_pkg::*;
#(
  parameter int unsigned STORE_LEN = 50
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic sclk,
  input wire logic frame_select_n,
  input wire logic din,
  input wire logic serial_out_o,
  input wire logic serial_out_oe,
  input wire logic done_o,
  input wire logic done_oe
);
  int unsigned busy_len;
  int unsigned falls;

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  // Store length, since an unbounded busy would hang the host
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || !done_oe) busy_len <= 0;
    else busy_len <= busy_len + 1;
  end

  // Falling link clock edges inside one frame
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || frame_select_n) falls <= 0;
    else if ($fell(sclk)) falls <= falls + 1;
  end

  od_pull_low_a: assert property ((serial_out_oe || done_oe) |->
    !(serial_out_o || done_o)) else $error("open drain drives high");
  sout_release_a: assert property (frame_select_n &&
    $past(frame_select_n) |-> !serial_out_oe) else $error("sout held");
  store_len_a: assert property ($fell(done_oe) |->
    busy_len >= STORE_LEN && busy_len <= STORE_LEN + 2)
    else $error("store length wrong");
  store_bound_a: assert property (busy_len <= STORE_LEN + 2)
    else $error("store too long");
  store_after_frame_a: assert property ($rose(done_oe) |->
    frame_select_n && $past(frame_select_n, 2)) else $error("early store");
  sclk_idle_a: assert property (frame_select_n &&
    $past(frame_select_n) |-> !sclk) else $error("clock outside frame");
  frame_lead_a: assert property ($fell(frame_select_n) |->
    !sclk [*4]) else $error("no frame lead");
  sclk_rate_a: assert property ($rose(sclk) |->
    sclk [*4] ##1 !sclk) else $error("link clock rate");
  din_stable_a: assert property ($fell(sclk) |-> $stable(din))
    else $error("data moved at sample");
  frame16_a: assert property ($rose(frame_select_n) |->
    falls == FRAME_BITS) else $error("frame not 16 bits");
endmodule

// file: verification/test_digipot_serial_wiper_control.sv
/*
  Bench for the serial wiper control: host and device on one link,
  a second device driven bit by bit for broken and locked frames.
  Assumes both devices use short store counts.
*/
`timescale 1ns/1ps
module test_digipot_serial_wiper_control
  import digipot_pkg::*;
;
  logic        core_clk, rst_n, por_n, start, busy, rd_valid;
  logic        dev_ready, shutdown;
  logic [3:0]  cmd, ctrl, ctrl2;
  logic [9:0]  data, wiper, wiper2;
  logic [15:0] rd_data;
  int          bad_count, comparisons, cycles, n;
  logic [9:0]  vals [4] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA};

  digipot_link_if link ();
  digipot_link_if link2 ();

  digipot_host digipot_host_inst (.CORE_CLK(core_clk), .RST_N(rst_n),
    .LINK(link.host), .START(start), .CMD(cmd), .DATA(data),
    .BUSY(busy), .RD_DATA(rd_data), .RD_VALID(rd_valid),
    .DEV_READY(dev_ready));
  digipot_device #(.STORE_LEN(50)) digipot_device_inst (
    .CORE_CLK(core_clk), .RST_N(rst_n), .POR_N(por_n),
    .LINK(link.dev), .WIPER(wiper), .SHUTDOWN(shutdown), .CTRL(ctrl));
  // Longer store so a whole frame fits inside the lock
  digipot_device #(.STORE_LEN(200)) digipot_device_inst_b (
    .CORE_CLK(core_clk), .RST_N(rst_n), .POR_N(por_n),
    .LINK(link2.dev), .WIPER(wiper2), .SHUTDOWN(), .CTRL(ctrl2));
  digipot_link_sva #(.STORE_LEN(50)) digipot_link_sva_inst (
    .CORE_CLK(core_clk), .RST_N(rst_n), .sclk(link.sclk),
    .frame_select_n(link.frame_select_n), .din(link.din),
    .serial_out_o(link.serial_out_o), .serial_out_oe(link.serial_out_oe),
    .done_o(link.done_o), .done_oe(link.done_oe));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk_val(input string nm, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic close_out();
    if (bad_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // One host request; returns after the answer and register settling
  task automatic send(input logic [3:0] c, input logic [9:0] d);
    n = 0;
    while (!(busy === 1'b0 && dev_ready === 1'b1) && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    cmd = c;
    data = d;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    n = 0;
    while (rd_valid !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    chk_bit("rd_valid", 1'b1, rd_valid);
    repeat (6) @(negedge core_clk);
  endtask

  // Bounded wait for op_done to reach a level
  task automatic wait_done(input logic lvl);
    n = 0;
    while (link.op_done !== lvl && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    chk_bit("op_done", lvl, link.op_done);
  endtask

  // Frame of nb bits on the spare link, 32 ns link clock
  task automatic bang(input logic [15:0] w, input int nb);
    link2.frame_select_n = 1'b0;
    #16;
    for (int i = 15; i > 15 - nb; i--) begin
      link2.din = w[i];
      link2.sclk = 1'b1;
      #16;
      link2.sclk = 1'b0;
      #16;
    end
    link2.frame_select_n = 1'b1;
    link2.din = ~link2.din; // Released line shows no stale value
    #200;
  endtask

  // Cuts a hang short
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end

  initial begin
    rst_n = 1'b0;
    por_n = 1'b0;
    start = 1'b0;
    cmd = 4'h0;
    data = 10'h000;
    link2.sclk = 1'b0;
    link2.frame_select_n = 1'b1;
    link2.din = 1'b0;
    repeat (19) @(negedge core_clk);
    por_n = 1'b1;
    @(negedge core_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    chk_val("wiper", {6'h00, WIPER_MID}, {6'h00, wiper});
    chk_val("ctrl", 16'h0000, {12'h000, ctrl});
    send(CMD_WR_WIPER, 10'h155);
    chk_val("wiper", {6'h00, WIPER_MID}, {6'h00, wiper});
    send(CMD_WR_CTRL, 10'h003);
    chk_val("ctrl", 16'h0003, {12'h000, ctrl});
    for (int i = 0; i < 4; i++) begin
      send(CMD_WR_WIPER, vals[i]);
      chk_val("wiper", {6'h00, vals[i]}, {6'h00, wiper});
    end
    send(CMD_RD_WIPER, 10'h000);
    send(CMD_RD_CTRL, 10'h000);
    chk_val("rd_wiper", 16'h02AA, rd_data);
    send(CMD_NOP, 10'h000);
    chk_val("rd_ctrl", 16'h0003, rd_data);
    send(CMD_STORE, 10'h3FF);
    wait_done(1'b0);
    repeat (4) @(negedge core_clk);
    chk_bit("dev_ready", 1'b0, dev_ready);
    wait_done(1'b1);
    chk_val("ctrl", 16'h000B, {12'h000, ctrl});
    send(CMD_WR_WIPER, 10'h155);
    chk_val("wiper", 16'h0155, {6'h00, wiper});
    send(CMD_REFRESH, 10'h000);
    chk_val("wiper", 16'h02AA, {6'h00, wiper});
    send(CMD_RD_FUSE, 10'h000);
    send(CMD_RD_FUSE, 10'h005);
    chk_val("rd_fuse", 16'h02AA, rd_data);
    send(CMD_NOP, 10'h000);
    chk_val("rd_used", 16'h0001, rd_data);
    send(CMD_SHUTDOWN, 10'h001);
    chk_bit("shutdown", 1'b1, shutdown);
    send(CMD_SHUTDOWN, 10'h000);
    chk_bit("shutdown", 1'b0, shutdown);
    rst_n = 1'b0;
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    chk_val("wiper", 16'h02AA, {6'h00, wiper});
    chk_val("ctrl", 16'h0000, {12'h000, ctrl});
    #3;
    bang({2'b00, CMD_WR_CTRL, 10'h003}, 16);
    chk_val("ctrl2", 16'h0003, {12'h000, ctrl2});
    bang({2'b00, CMD_WR_WIPER, 10'h3FF}, 15);
    chk_val("wiper2", {6'h00, WIPER_MID}, {6'h00, wiper2});
    bang({2'b00, CMD_WR_WIPER, 10'h3FF}, 16);
    chk_val("wiper2", 16'h03FF, {6'h00, wiper2});
    bang({2'b00, CMD_STORE, 10'h000}, 16);
    bang({2'b00, CMD_WR_WIPER, 10'h011}, 16);
    chk_bit("op_done2", 1'b0, link2.op_done);
    chk_val("wiper2", 16'h03FF, {6'h00, wiper2});
    #2000;
    chk_bit("op_done2", 1'b1, link2.op_done);
    chk_val("ctrl2", 16'h000B, {12'h000, ctrl2});
    close_out();
  end
endmodule

// file: verilog/bit_sync.sv
/*
  Two-flop synchroniser for one level. Assumes a synchronous
  active-low reset in the destination clock domain.
*/
`timescale 1ns/1ps
module bit_sync #(
  parameter logic INIT = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic meta;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= INIT;
      q    <= INIT;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// file: verilog/digipot_device.sv
/*
  Device end of the serial wiper control: 16-bit framed shift
  register on the link clock, command decode, wiper register,
  control bits, fuse wiper memory with timed store, readback.
  Assumes a host that keeps frames quiet while op_done is low and
  leaves a few core cycles between frames.
*/
// What this block does
// - Sample din on falling serial clock edge
// - Host keeps serial clock at most 50 MHz
// - Shift only while frame select is low
// - Update register on select rise after 16
// - Early select rise aborts, nothing changes
// - serial_out is open drain, pulls low only
// - Shift register contents leave on serial_out unless a readback word is pending
// - op_done high reports operation complete
// - Wiper output follows wiper setting register
// - Wiper register accepts unlimited writes
// - One 16-bit word sets any wiper position
// - Command copies wiper into fuse memory
// - Power-up restores last stored fuse value
// - Fuse store lasts about 6 ms
// - Frames ignored while store in progress
// - op_done marks end of fuse store
// - Wiper, shutdown and control bits 2:0 writable via serial frame
// - Word: two zeros, four command, ten data
// - Command 1 loads ten data bits
// - Command 3 stores wiper to fuse memory
// - Wiper writes locked until unlock bit set
`timescale 1ns/1ps
module digipot_device
  import digipot_pkg::*;
#(
  parameter int unsigned STORE_LEN = STORE_CYCLES
) (
  input  wire logic         CORE_CLK,
  input  wire logic         RST_N,
  input  wire logic         POR_N,
  digipot_link_if.dev       LINK,
  output logic [9:0]        WIPER,
  output logic              SHUTDOWN,
  output logic [CTRL_BITS-1:0] CTRL
);

  typedef enum logic {ST_IDLE, ST_STORE} store_state_t;

  // Link clock domain
  logic [FRAME_BITS-1:0] shift_reg;
  logic [3:0]            bit_cnt;
  logic                  seen_full;
  logic                  pull_low;
  logic                  frame_whole;

  // Core clock domain
  logic                      fs_sync;
  logic                      fs_prev;
  logic                      frame_end;
  logic                      frame_ok;
  logic                      take;
  logic [3:0]                cmd;
  logic [DATA_BITS-1:0]      data;
  logic                      rb_active;
  logic [FRAME_BITS-1:0]     rb_word;
  store_state_t              state;
  logic [STORE_TMR_BITS-1:0] store_tmr;
  logic                      store_done;
  logic [DATA_BITS-1:0]      fuse_mem [FUSE_SLOTS];
  logic [ADDR_BITS-1:0]      fuse_used;
  logic                      done_busy;

  // Last stored value, or midscale on a blank memory
  function automatic logic [DATA_BITS-1:0] restore_value(
    input logic [ADDR_BITS-1:0] used
  );
    logic [DATA_BITS-1:0] v;
    v = WIPER_MID;
    if (used != '0) begin
      v = fuse_mem[used - 5'h01];
    end
    return v;
  endfunction

  // Bit counter, cleared asynchronously between frames
  always_ff @(negedge LINK.sclk or posedge LINK.frame_select_n) begin
    if (LINK.frame_select_n) begin
      bit_cnt   <= 4'h0;
      seen_full <= 1'b0;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
      if (bit_cnt == LAST_BIT) begin
        seen_full <= 1'b1;
      end
    end
  end

  // Shift in on falling edges while selected
  always_ff @(negedge LINK.sclk) begin
    if (!LINK.frame_select_n) begin
      shift_reg <= {shift_reg[FRAME_BITS-2:0], LINK.din};
    end
  end

  // Frame verdict on the select rise; the same edge clears the
  // counter, so the verdict must be latched before the core sees it
  always_ff @(posedge LINK.frame_select_n) begin
    frame_whole <= seen_full & (bit_cnt == 4'h0);
  end

  // Output changes on rising edges so the host samples on falling.
  // rb_word and rb_active only change between frames.
  always_ff @(posedge LINK.sclk or posedge LINK.frame_select_n) begin
    if (LINK.frame_select_n) begin
      pull_low <= 1'b0;
    end else if (rb_active) begin
      pull_low <= ~rb_word[LAST_BIT - bit_cnt];
    end else begin
      pull_low <= ~shift_reg[FRAME_BITS-1];
    end
  end

  // Open drain: only ever pull low
  assign LINK.serial_out_o  = 1'b0;
  assign LINK.serial_out_oe = pull_low;

  // Frame select into the core domain
  bit_sync #(.INIT(1'b1)) u_fs_sync (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .d     (LINK.frame_select_n),
    .q     (fs_sync)
  );

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      fs_prev <= 1'b1;
    end else begin
      fs_prev <= fs_sync;
    end
  end

  // Shift register is quiet once select has risen, so it is read here.
  // A whole multiple of 16 bits counts; anything else is an abort.
  assign frame_end = fs_sync & ~fs_prev;
  assign frame_ok  = frame_whole;
  assign take      = frame_end & frame_ok & (state == ST_IDLE);
  assign cmd       = shift_reg[CMD_HI:CMD_LO];
  assign data      = shift_reg[DATA_BITS-1:0];

  // Wiper setting register, reloaded from fuse memory on reset
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      WIPER <= restore_value(fuse_used);
    end else if (take) begin
      if (cmd == CMD_WR_WIPER && CTRL[CTRL_WIPER_EN]) begin
        WIPER <= data;
      end else if (cmd == CMD_REFRESH) begin
        WIPER <= restore_value(fuse_used);
      end
    end
  end

  // Control register; store result set by hardware wins over a write
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      CTRL <= CTRL_RESET;
    end else begin
      if (take && cmd == CMD_WR_CTRL) begin
        CTRL[CTRL_PERF:CTRL_FUSE_EN] <= data[CTRL_PERF:CTRL_FUSE_EN];
        CTRL[CTRL_STORE_OK] <= 1'b0;
      end
      if (take && cmd == CMD_STORE && CTRL[CTRL_FUSE_EN]) begin
        CTRL[CTRL_STORE_OK] <= 1'b0;
      end
      if (store_done && fuse_used != FUSE_LAST) begin
        CTRL[CTRL_STORE_OK] <= 1'b1;
      end
    end
  end

  // Software shutdown flag
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      SHUTDOWN <= 1'b0;
    end else if (take && cmd == CMD_SHUTDOWN) begin
      SHUTDOWN <= data[0];
    end
  end

  // Readback word for the following frame; cleared by any valid frame without a read command
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      rb_active <= 1'b0;
      rb_word   <= '0;
    end else if (take) begin
      rb_active <= 1'b1;
      case (cmd)
        CMD_RD_WIPER: begin
          rb_word <= {6'h00, WIPER};
        end
        CMD_RD_FUSE: begin
          if (data[ADDR_BITS-1:0] < fuse_used) begin
            rb_word <= {6'h00, fuse_mem[data[ADDR_BITS-1:0]]};
          end else begin
            rb_word <= {11'h000, fuse_used}; // Status: slots used
          end
        end
        CMD_RD_CTRL: begin
          rb_word <= {12'h000, CTRL};
        end
        default: begin
          rb_active <= 1'b0;
        end
      endcase
    end
  end

  // Store sequence; the timer stands for the fuse burn time
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      state      <= ST_IDLE;
      store_tmr  <= '0;
      store_done <= 1'b0;
    end else begin
      store_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (take && cmd == CMD_STORE && CTRL[CTRL_FUSE_EN] &&
              fuse_used != FUSE_LAST) begin
            state     <= ST_STORE;
            store_tmr <= '0;
          end
        end
        ST_STORE: begin
          if (store_tmr == STORE_TMR_BITS'(STORE_LEN - 1)) begin
            state      <= ST_IDLE;
            store_done <= 1'b1;
          end else begin
            store_tmr <= store_tmr + 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Fuse memory survives RST_N; only POR_N blanks it
  always_ff @(posedge CORE_CLK) begin
    if (!POR_N) begin
      fuse_used <= '0;
    end else if (store_done && fuse_used != FUSE_LAST) begin
      fuse_mem[fuse_used] <= WIPER;
      fuse_used           <= fuse_used + 5'h01;
    end
  end

  // Ready line pulled low while a store runs
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      done_busy <= 1'b0;
    end else begin
      done_busy <= (state == ST_STORE) && !store_done;
    end
  end

  assign LINK.done_o  = 1'b0;
  assign LINK.done_oe = done_busy;

endmodule

// file: verilog/digipot_host.sv
/*
  Host end of the serial wiper control link. Divides the core clock
  into the link clock, sends one 16-bit word per request and returns
  the word seen on serial_out during that frame.
  Assumes START is a core-clock signal from local logic.
*/
`timescale 1ns/1ps
module digipot_host
  import digipot_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  digipot_link_if.host     LINK,
  input  wire logic        START,
  input  wire logic [3:0]  CMD,
  input  wire logic [9:0]  DATA,
  output logic             BUSY,
  output logic [15:0]      RD_DATA,
  output logic             RD_VALID,
  output logic             DEV_READY
);

  typedef enum logic [2:0] {
    H_IDLE, H_LEAD, H_HIGH, H_LOW, H_TAIL, H_GAP
  } host_state_t;

  host_state_t           state;
  logic [3:0]            tmr;
  logic [3:0]            bit_idx;
  logic [FRAME_BITS-1:0] tx;
  logic [FRAME_BITS-1:0] rx;
  logic                  sdo_sync;
  logic                  rdy_sync;
  logic                  sclk;
  logic                  fs_n;
  logic                  din;
  logic                  half_done;

  bit_sync #(.INIT(1'b1)) u_sdo_sync (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .d     (LINK.serial_out),
    .q     (sdo_sync)
  );

  bit_sync #(.INIT(1'b0)) u_rdy_sync (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .d     (LINK.op_done),
    .q     (rdy_sync)
  );

  assign LINK.sclk           = sclk;
  assign LINK.frame_select_n = fs_n;
  assign LINK.din            = din;
  assign half_done = (state == H_GAP) ? (tmr == GAP_CYCLES - 4'h1)
                                      : (tmr == SCLK_HALF - 4'h1);

  // Half-period divider keeps the link clock well under 50 MHz
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || state == H_IDLE || half_done) begin
      tmr <= 4'h0;
    end else begin
      tmr <= tmr + 4'h1;
    end
  end

  // Frame sequencer; din changes on rising edges
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      state    <= H_IDLE;
      sclk     <= 1'b0;
      fs_n     <= 1'b1;
      din      <= 1'b0;
      tx       <= '0;
      rx       <= '0;
      bit_idx  <= 4'h0;
      BUSY     <= 1'b0;
      RD_DATA  <= '0;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= 1'b0;
      case (state)
        H_IDLE: begin
          if (START && rdy_sync) begin
            tx      <= {2'b00, CMD, DATA};
            fs_n    <= 1'b0;
            bit_idx <= 4'h0;
            BUSY    <= 1'b1;
            state   <= H_LEAD;
          end
        end
        H_LEAD, H_LOW: begin
          if (half_done) begin
            if (state == H_LOW && bit_idx == LAST_BIT) begin
              state <= H_TAIL;
            end else begin
              if (state == H_LOW) begin
                bit_idx <= bit_idx + 4'h1;
              end
              sclk  <= 1'b1;
              din   <= tx[FRAME_BITS-1];
              tx    <= {tx[FRAME_BITS-2:0], 1'b0};
              state <= H_HIGH;
            end
          end
        end
        H_HIGH: begin
          if (half_done) begin
            sclk  <= 1'b0;
            rx    <= {rx[FRAME_BITS-2:0], sdo_sync};
            state <= H_LOW;
          end
        end
        H_TAIL: begin
          if (half_done) begin
            fs_n     <= 1'b1;
            RD_DATA  <= rx;
            RD_VALID <= 1'b1;
            state    <= H_GAP;
          end
        end
        H_GAP: begin
          if (half_done) begin
            BUSY  <= 1'b0;
            state <= H_IDLE;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      DEV_READY <= 1'b0;
    end else begin
      DEV_READY <= rdy_sync;
    end
  end

endmodule

// file: verilog/digipot_link_if.sv
/*
  Serial link between the wiper control device and its host.
  Open-drain lines resolve here against an assumed pull-up.
*/
`timescale 1ns/1ps
interface digipot_link_if;
  logic sclk;            // Link clock, idles low
  logic frame_select_n;  // Frame select, active low
  logic din;             // Data to the device
  logic serial_out_o;    // Device pull-down level (always low)
  logic serial_out_oe;   // Device pulls serial_out low
  logic done_o;          // Device pull-down level (always low)
  logic done_oe;         // Device pulls op_done low while busy
  wire  serial_out;
  wire  op_done;

  // Pull-up resolution of the open-drain pins
  assign serial_out = serial_out_oe ? serial_out_o : 1'b1;
  assign op_done    = done_oe ? done_o : 1'b1;

  modport dev (
    input  sclk,
    input  frame_select_n,
    input  din,
    output serial_out_o,
    output serial_out_oe,
    output done_o,
    output done_oe
  );

  modport host (
    output sclk,
    output frame_select_n,
    output din,
    input  serial_out,
    input  op_done
  );
endinterface

// file: verilog/digipot_pkg.sv
/*
  Shared constants for the serial wiper control link: frame layout,
  command codes, control bits, fuse memory size and timing counts.
  Assumes both ends and the bench import it whole.
*/
package digipot_pkg;

  // Frame layout, most significant bit sent first
  localparam int          FRAME_BITS = 16;
  localparam logic [3:0]  LAST_BIT   = 4'hF;
  localparam int          CMD_HI     = 13;
  localparam int          CMD_LO     = 10;
  localparam int          DATA_BITS  = 10;
  localparam int          ADDR_BITS  = 5;

  // Command codes
  localparam logic [3:0] CMD_NOP        = 4'h0;
  localparam logic [3:0] CMD_WR_WIPER   = 4'h1;
  localparam logic [3:0] CMD_RD_WIPER   = 4'h2;
  localparam logic [3:0] CMD_STORE      = 4'h3;
  localparam logic [3:0] CMD_REFRESH    = 4'h4;
  localparam logic [3:0] CMD_RD_FUSE    = 4'h5;
  localparam logic [3:0] CMD_WR_CTRL    = 4'h6;
  localparam logic [3:0] CMD_RD_CTRL    = 4'h7;
  localparam logic [3:0] CMD_SHUTDOWN   = 4'h8;

  // Control register bits
  localparam int CTRL_BITS       = 4;
  localparam int CTRL_FUSE_EN    = 0;
  localparam int CTRL_WIPER_EN   = 1;
  localparam int CTRL_PERF       = 2;
  localparam int CTRL_STORE_OK   = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // Wiper and fuse memory
  localparam logic [9:0] WIPER_MID  = 10'h200;
  localparam int         FUSE_SLOTS = 20;
  localparam logic [4:0] FUSE_LAST  = 5'h14;

  // Timing at the 125 MHz core clock
  localparam int CORE_PERIOD_NS = 8;
  localparam int STORE_TIME_US  = 6000;
  localparam int STORE_CYCLES   = STORE_TIME_US * 1000 / CORE_PERIOD_NS;
  localparam int STORE_TMR_BITS = 20;
  localparam int SCLK_MAX_MHZ   = 50;
  localparam logic [3:0] SCLK_HALF  = 4'h4;
  localparam logic [3:0] GAP_CYCLES = 4'h8;

endpackage
